// *** design/scpd_device.sv ***
`timescale 1ns/10ps
`default_nettype none
module scpd_device #(
    parameter logic [6:0] NODE_DEFAULT = scpd_pkg::NODE_DEFAULT,
    parameter int BUF_DEPTH = scpd_pkg::BUF_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    scpd_link_if.dev link,
    input wire logic node_wr,
    input wire logic [6:0] node_din,
    input wire logic crc_en_wr,
    input wire logic crc_en_din,
    output logic [6:0] node_num,
    output logic crc_en,
    output logic exec_valid,
    output logic [7:0] exec_cmd,
    output scpd_pkg::scpd_fmt_type exec_fmt,
    output logic [31:0] exec_value,
    output logic [6:0] exec_offset,
    output logic [6:0] exec_len,
    output logic crc_error,
    output logic [7:0] src_addr,
    input wire logic src_valid,
    input wire logic [7:0] src_data,
    output logic src_ready,
    output logic tx_busy
);
    typedef enum logic [2:0] {ST_IDLE, ST_NODE, ST_ACMD, ST_DATA, ST_CRC} scpd_state_type;

    scpd_state_type state_ff;
    logic [6:0] node_ff;
    logic crc_en_ff;
    logic addr_ff;
    logic match_ff;
    logic [7:0] cmd_ff;
    scpd_pkg::scpd_fmt_type fmt_ff;
    logic [2:0] need_ff;
    logic [2:0] cnt_ff;
    logic [6:0] crc_ff;
    logic [6:0] data_ff [5];
    logic fire_ff;
    logic [6:0] left_ff;

    logic take;
    logic [7:0] rx;
    logic is_cmd;
    scpd_pkg::scpd_fmt_type fmt_now;
    logic [2:0] need_now;
    logic [2:0] cnt_inc;
    logic body_end;
    logic crc_chk;
    logic crc_ok;
    logic for_us;
    logic fire;
    logic crc_bad;
    logic buf_in_ready;
    logic src_take;

    // Bytes are consumed every cycle; back-pressure lives only on the reply path
    assign link.cmd_ready = 1'b1;
    assign take = link.cmd_valid;
    assign rx = link.cmd_byte;
    assign is_cmd = rx[scpd_pkg::CMD_BIT];
    // After the node byte the command arrives with its top bit cleared
    assign fmt_now = scpd_pkg::scpd_fmt_of({1'b1, rx[6:0]});
    assign need_now = scpd_pkg::scpd_need(fmt_now);
    assign cnt_inc = cnt_ff + 3'h1;
    assign node_num = node_ff;
    assign crc_en = crc_en_ff;

    // Body complete with the byte now taken
    always_comb begin
        body_end = 1'b0;
        if (take) begin
            if (is_cmd) begin
                body_end = (rx != scpd_pkg::ADDR_CMD) && (need_now == scpd_pkg::NEED_QUICK);
            end else if (state_ff == ST_ACMD) begin
                body_end = need_now == scpd_pkg::NEED_QUICK;
            end else if (state_ff == ST_DATA) begin
                body_end = cnt_inc == need_ff;
            end
        end
    end

    assign crc_chk = take && !is_cmd && (state_ff == ST_CRC);
    assign crc_ok = rx[6:0] == crc_ff;
    // A fresh command byte other than the prefix starts a compact packet, so it is ours
    assign for_us = is_cmd || !addr_ff || match_ff;
    assign fire = for_us && ((body_end && !crc_en_ff) || (crc_chk && crc_ok));
    assign crc_bad = for_us && crc_chk && !crc_ok;

    always_ff @(posedge clk) begin
        if (rst) begin
            node_ff <= NODE_DEFAULT;
            crc_en_ff <= scpd_pkg::CRC_EN_DEFAULT;
        end else begin
            if (node_wr) begin
                node_ff <= node_din;
            end
            if (crc_en_wr) begin
                crc_en_ff <= crc_en_din;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            addr_ff <= 1'b0;
            match_ff <= 1'b0;
            cmd_ff <= 8'h00;
            fmt_ff <= scpd_pkg::FMT_QUICK;
            need_ff <= 3'h0;
            cnt_ff <= 3'h0;
            crc_ff <= 7'h00;
        end else if (take) begin
            // Checksum runs over every byte of the packet, prefix included
            crc_ff <= scpd_pkg::scpd_crc_step(is_cmd ? 7'h00 : crc_ff, rx);
            if (is_cmd) begin
                // Any command byte drops a half-received packet
                addr_ff <= rx == scpd_pkg::ADDR_CMD;
                match_ff <= 1'b0;
                cmd_ff <= rx;
                fmt_ff <= fmt_now;
                need_ff <= need_now;
                cnt_ff <= 3'h0;
                if (rx == scpd_pkg::ADDR_CMD) begin
                    state_ff <= ST_NODE;
                end else if (need_now == scpd_pkg::NEED_QUICK) begin
                    state_ff <= crc_en_ff ? ST_CRC : ST_IDLE;
                end else begin
                    state_ff <= ST_DATA;
                end
            end else begin
                case (state_ff)
                    ST_NODE: begin
                        match_ff <= rx[6:0] == node_ff;
                        state_ff <= ST_ACMD;
                    end
                    ST_ACMD: begin
                        cmd_ff <= {1'b1, rx[6:0]};
                        fmt_ff <= fmt_now;
                        need_ff <= need_now;
                        cnt_ff <= 3'h0;
                        if (need_now == scpd_pkg::NEED_QUICK) begin
                            state_ff <= crc_en_ff ? ST_CRC : ST_IDLE;
                        end else begin
                            state_ff <= ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        cnt_ff <= cnt_inc;
                        if (cnt_inc == need_ff) begin
                            state_ff <= crc_en_ff ? ST_CRC : ST_IDLE;
                        end
                    end
                    ST_CRC: begin
                        state_ff <= ST_IDLE;
                    end
                    default: begin
                        // Stray data byte outside a packet is dropped
                        state_ff <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (take && !is_cmd && (state_ff == ST_DATA)) begin
            data_ff[cnt_ff] <= rx[6:0];
        end
    end

    // One cycle of slack lets the last data byte land before assembly;
    // a following packet cannot write data before that cycle ends
    always_ff @(posedge clk) begin
        if (rst) begin
            fire_ff <= 1'b0;
            crc_error <= 1'b0;
            exec_valid <= 1'b0;
            exec_cmd <= 8'h00;
            exec_fmt <= scpd_pkg::FMT_QUICK;
            exec_value <= 32'h0000_0000;
            exec_offset <= 7'h00;
            exec_len <= 7'h00;
        end else begin
            fire_ff <= fire;
            crc_error <= crc_bad;
            exec_valid <= fire_ff;
            if (fire_ff) begin
                exec_cmd <= cmd_ff;
                exec_fmt <= fmt_ff;
                exec_offset <= 7'h00;
                exec_len <= 7'h00;
                case (fmt_ff)
                    scpd_pkg::FMT_W7: begin
                        exec_value <= {25'h0, data_ff[0]};
                    end
                    scpd_pkg::FMT_W32: begin
                        exec_value <= {data_ff[0][3], data_ff[4], data_ff[0][2], data_ff[3],
                                       data_ff[0][1], data_ff[2], data_ff[0][0], data_ff[1]};
                    end
                    scpd_pkg::FMT_READ: begin
                        exec_value <= 32'h0000_0000;
                        exec_offset <= data_ff[0];
                        exec_len <= data_ff[1];
                    end
                    default: begin
                        exec_value <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // Reply: fetch bytes at rising addresses so stored values leave low byte first;
    // no trailer is ever added, whatever the checksum setting
    assign src_ready = (left_ff != 7'h00) && buf_in_ready;
    assign src_take = src_valid && src_ready;
    assign tx_busy = (left_ff != 7'h00) || link.rsp_valid;

    always_ff @(posedge clk) begin
        if (rst) begin
            left_ff <= 7'h00;
            src_addr <= 8'h00;
        end else if (fire_ff && (fmt_ff == scpd_pkg::FMT_READ)) begin
            left_ff <= data_ff[1];
            src_addr <= {1'b0, data_ff[0]};
        end else if (src_take) begin
            left_ff <= left_ff - 7'h01;
            src_addr <= src_addr + 8'h01;
        end
    end

    scpd_buf2 #(
        .WIDTH(8),
        .DEPTH(BUF_DEPTH)
    ) u_rsp_buf (
        .clk(clk),
        .rst(rst),
        .in_valid(src_take),
        .in_ready(buf_in_ready),
        .in_data(src_data),
        .out_valid(link.rsp_valid),
        .out_ready(link.rsp_ready),
        .out_data(link.rsp_byte)
    );
endmodule
`default_nettype wire

// *** design/scpd_pkg.sv ***
package scpd_pkg;
    localparam int CMD_BIT = 7;
    localparam logic [7:0] ADDR_CMD = 8'hAA;
    localparam logic [6:0] NODE_DEFAULT = 7'h0E;
    localparam logic [7:0] CRC_POLY = 8'h91;
    localparam logic CRC_EN_DEFAULT = 1'b0;
    localparam logic [6:0] RD_LEN_MIN = 7'h01;
    localparam logic [6:0] RD_LEN_MAX = 7'h0F;
    localparam logic [2:0] NEED_QUICK = 3'h0;
    localparam logic [2:0] NEED_W7 = 3'h1;
    localparam logic [2:0] NEED_W32 = 3'h5;
    localparam logic [2:0] NEED_READ = 3'h2;
    localparam int BODY_MAX = 9;
    localparam int BUF_DEPTH = 2;

    typedef enum logic [1:0] {FMT_QUICK, FMT_W7, FMT_W32, FMT_READ} scpd_fmt_type;

    // Command groups by high nibble: 8x quick, 9x 7-bit write, Ax block read, Bx..Fx 32-bit write
    function automatic scpd_fmt_type scpd_fmt_of(input logic [7:0] cmd);
        if (cmd[6:4] == 3'h0) begin
            return FMT_QUICK;
        end else if (cmd[6:4] == 3'h1) begin
            return FMT_W7;
        end else if (cmd[6:4] == 3'h2) begin
            return FMT_READ;
        end else begin
            return FMT_W32;
        end
    endfunction

    function automatic logic [2:0] scpd_need(input scpd_fmt_type fmt);
        case (fmt)
            FMT_W7: return NEED_W7;
            FMT_W32: return NEED_W32;
            FMT_READ: return NEED_READ;
            default: return NEED_QUICK;
        endcase
    endfunction

    // One byte, least significant bit first
    function automatic logic [6:0] scpd_crc_step(input logic [6:0] crc, input logic [7:0] b);
        logic [7:0] r;
        r = {1'b0, crc} ^ b;
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r ^ CRC_POLY) >> 1) : (r >> 1);
        end
        return r[6:0];
    endfunction
endpackage

// *** design/scpd_link_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface scpd_link_if;
    logic cmd_valid;
    logic cmd_ready;
    logic [7:0] cmd_byte;
    logic rsp_valid;
    logic rsp_ready;
    logic [7:0] rsp_byte;

    modport host (
        output cmd_valid,
        input cmd_ready,
        output cmd_byte,
        input rsp_valid,
        output rsp_ready,
        input rsp_byte
    );

    modport dev (
        input cmd_valid,
        output cmd_ready,
        input cmd_byte,
        output rsp_valid,
        input rsp_ready,
        output rsp_byte
    );
endinterface
`default_nettype wire

// *** design/scpd_buf2.sv ***
`timescale 1ns/10ps
`default_nettype none
module scpd_buf2 #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0] cnt_ff;
    logic push;
    logic pop;

    assign in_ready = cnt_ff != FULL;
    assign out_valid = cnt_ff != '0;
    assign out_data = mem_ff[rd_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= (wr_ff == LAST) ? '0 : wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= (rd_ff == LAST) ? '0 : rd_ff + 1'b1;
            end
            if (push && !pop) begin
                cnt_ff <= cnt_ff + 1'b1;
            end else if (pop && !push) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// *** design/scpd_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module scpd_host (
    input wire logic clk,
    input wire logic rst,
    scpd_link_if.host link,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [7:0] req_cmd,
    input wire logic [31:0] req_value,
    input wire logic req_addressed,
    input wire logic [6:0] req_node,
    input wire logic crc_en,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    input wire logic rsp_ready,
    output logic busy
);
    logic busy_ff;
    logic crc_on_ff;
    logic [7:0] pkt_ff [scpd_pkg::BODY_MAX];
    logic [3:0] n_ff;
    logic [3:0] idx_ff;
    logic [6:0] crc_ff;
    logic [7:0] pb [scpd_pkg::BODY_MAX];
    logic [3:0] k;
    logic [6:0] rd_len;
    logic send;
    logic at_trailer;
    logic last;

    assign req_ready = !busy_ff;
    assign busy = busy_ff;

    // Host keeps the length inside what the device can answer
    always_comb begin
        rd_len = req_value[14:8];
        if (rd_len < scpd_pkg::RD_LEN_MIN) begin
            rd_len = scpd_pkg::RD_LEN_MIN;
        end else if (rd_len > scpd_pkg::RD_LEN_MAX) begin
            rd_len = scpd_pkg::RD_LEN_MAX;
        end
    end

    always_comb begin
        k = 4'h0;
        for (int i = 0; i < scpd_pkg::BODY_MAX; i++) begin
            pb[i] = 8'h00;
        end
        if (req_addressed) begin
            pb[0] = scpd_pkg::ADDR_CMD;
            pb[1] = {1'b0, req_node};
            pb[2] = {1'b0, req_cmd[6:0]};
            k = 4'h3;
        end else begin
            pb[0] = {1'b1, req_cmd[6:0]};
            k = 4'h1;
        end
        case (scpd_pkg::scpd_fmt_of(req_cmd))
            scpd_pkg::FMT_W7: begin
                pb[k] = {1'b0, req_value[6:0]};
                k = k + 4'h1;
            end
            scpd_pkg::FMT_W32: begin
                pb[k] = {4'h0, req_value[31], req_value[23], req_value[15], req_value[7]};
                pb[k + 4'h1] = {1'b0, req_value[6:0]};
                pb[k + 4'h2] = {1'b0, req_value[14:8]};
                pb[k + 4'h3] = {1'b0, req_value[22:16]};
                pb[k + 4'h4] = {1'b0, req_value[30:24]};
                k = k + 4'h5;
            end
            scpd_pkg::FMT_READ: begin
                pb[k] = {1'b0, req_value[6:0]};
                pb[k + 4'h1] = {1'b0, rd_len};
                k = k + 4'h2;
            end
            default: begin
                k = k + 4'h0;
            end
        endcase
    end

    assign at_trailer = idx_ff == n_ff;
    assign link.cmd_valid = busy_ff;
    assign link.cmd_byte = at_trailer ? {1'b0, crc_ff} : pkt_ff[idx_ff];
    assign send = busy_ff && link.cmd_ready;
    assign last = crc_on_ff ? at_trailer : (idx_ff == n_ff - 4'h1);

    always_ff @(posedge clk) begin
        if (req_valid && !busy_ff) begin
            pkt_ff <= pb;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            busy_ff <= 1'b0;
            crc_on_ff <= 1'b0;
            n_ff <= 4'h0;
            idx_ff <= 4'h0;
            crc_ff <= 7'h00;
        end else if (req_valid && !busy_ff) begin
            busy_ff <= 1'b1;
            crc_on_ff <= crc_en;
            n_ff <= k;
            idx_ff <= 4'h0;
            crc_ff <= 7'h00;
        end else if (send) begin
            crc_ff <= scpd_pkg::scpd_crc_step(crc_ff, link.cmd_byte);
            idx_ff <= idx_ff + 4'h1;
            if (last) begin
                busy_ff <= 1'b0;
            end
        end
    end

    assign link.rsp_ready = !rsp_valid || rsp_ready;

    always_ff @(posedge clk) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_data <= 8'h00;
        end else if (link.rsp_ready) begin
            rsp_valid <= link.rsp_valid;
            if (link.rsp_valid) begin
                rsp_data <= link.rsp_byte;
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/scpd_link_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module scpd_link_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic [7:0] cmd_byte,
    input wire logic rsp_valid,
    input wire logic rsp_ready,
    input wire logic [7:0] rsp_byte
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence data_byte;
        cmd_valid && !cmd_byte[7];
    endsequence
    chk_reset_idle: assert property (disable iff (1'b0) rst |=> !cmd_valid && !rsp_valid)
        else $error("link active after reset");
    chk_cmd_ready_high: assert property (cmd_ready)
        else $error("device stalled a command byte");
    chk_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_byte))
        else $error("reply byte dropped or changed while stalled");
    chk_cmd_first: assert property ($rose(cmd_valid) |-> cmd_byte[7])
        else $error("packet does not open with a command byte");
    chk_w7_body: assert property ($rose(cmd_valid) && cmd_byte[7:4] == 4'h9 |=> data_byte)
        else $error("7-bit write without its data byte");
    chk_w32_body: assert property ($rose(cmd_valid) && cmd_byte[7:4] >= 4'hB |=> data_byte [*5])
        else $error("32-bit write body short or marked");
    chk_read_body: assert property ($rose(cmd_valid) && cmd_byte[7:4] == 4'hA |=> data_byte [*2])
        else $error("block read without offset and length");
    chk_addr_prefix: assert property ($rose(cmd_valid) && cmd_byte == 8'hAA |=> data_byte [*2])
        else $error("addressed packet prefix malformed");
    cover property ($rose(cmd_valid) && cmd_byte[7:4] >= 4'hB);
    cover property ($rose(cmd_valid) && cmd_byte == 8'hAA);
    cover property (rsp_valid && !rsp_ready);
endmodule
`default_nettype wire

// *** tb/serial_command_packet_decoder_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module serial_command_packet_decoder_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0, req_addr = 1'b0, hcrc = 1'b0, hrsp_ready = 1'b0;
    logic node_wr = 1'b0, crc_wr = 1'b0, crc_din = 1'b0, src_valid = 1'b0;
    logic [7:0] req_cmd = 8'h00;
    logic [31:0] req_value = 32'h0;
    logic [6:0] req_node = 7'h00, node_din = 7'h00;
    logic req_ready, hrsp_valid, hbusy, exec_valid, crc_error, src_ready, ev2, ce2, crc_en, tx_busy;
    logic [7:0] hrsp_data, exec_cmd, src_addr, ec2;
    logic [31:0] exec_value, evl2;
    logic [6:0] exec_offset, exec_len, eo2, el2, node_num;
    scpd_pkg::scpd_fmt_type exec_fmt, ef2;
    logic [55:0] ev_q[$];
    logic [7:0] rsp_q[$];
    int err_total = 0, comparisons = 0, seed = 23032;
    // Reply source behaves as a zero-latency table; values use all eight bits, though only addresses up to offset 127 plus 14 are reached
    wire logic [7:0] src_data = src_addr ^ 8'hC3;
    scpd_link_if lnk();
    scpd_link_if lnk2();
    scpd_host scpd_host_i (.clk(clk), .rst(rst), .link(lnk), .req_valid(req_valid), .req_ready(req_ready),
        .req_cmd(req_cmd), .req_value(req_value), .req_addressed(req_addr), .req_node(req_node), .crc_en(hcrc),
        .rsp_valid(hrsp_valid), .rsp_data(hrsp_data), .rsp_ready(hrsp_ready), .busy(hbusy));
    scpd_device scpd_device_i (.clk(clk), .rst(rst), .link(lnk), .node_wr(node_wr), .node_din(node_din),
        .crc_en_wr(crc_wr), .crc_en_din(crc_din), .node_num(node_num), .crc_en(crc_en), .exec_valid(exec_valid),
        .exec_cmd(exec_cmd), .exec_fmt(exec_fmt), .exec_value(exec_value), .exec_offset(exec_offset),
        .exec_len(exec_len), .crc_error(crc_error), .src_addr(src_addr), .src_valid(src_valid),
        .src_data(src_data), .src_ready(src_ready), .tx_busy(tx_busy));
    // Second device is fed raw bytes so malformed packets can be injected
    scpd_device scpd_device_i2 (.clk(clk), .rst(rst), .link(lnk2), .node_wr(node_wr), .node_din(node_din),
        .crc_en_wr(crc_wr), .crc_en_din(crc_din), .node_num(), .crc_en(), .exec_valid(ev2), .exec_cmd(ec2),
        .exec_fmt(ef2), .exec_value(evl2), .exec_offset(eo2), .exec_len(el2), .crc_error(ce2), .src_addr(),
        .src_valid(1'b0), .src_data(8'h00), .src_ready(), .tx_busy());
    scpd_link_asserts scpd_link_asserts_i (.clk(clk), .rst(rst), .cmd_valid(lnk.cmd_valid),
        .cmd_ready(lnk.cmd_ready), .cmd_byte(lnk.cmd_byte), .rsp_valid(lnk.rsp_valid),
        .rsp_ready(lnk.rsp_ready), .rsp_byte(lnk.rsp_byte));

    initial begin
        forever #25 clk = ~clk;
    end

    function automatic logic [55:0] exp_of(input logic [7:0] c, input logic [31:0] v);
        logic [6:0] ln;
        ln = (v[14:8] == 7'h00) ? 7'h01 : (v[14:8] > 7'h0F) ? 7'h0F : v[14:8];
        case (c[6:4])
            3'h0: return {c | 8'h80, scpd_pkg::FMT_QUICK, 46'h0};
            3'h1: return {c | 8'h80, scpd_pkg::FMT_W7, 25'h0, v[6:0], 14'h0};
            3'h2: return {c | 8'h80, scpd_pkg::FMT_READ, 32'h0, v[6:0], ln};
            default: return {c | 8'h80, scpd_pkg::FMT_W32, v, 14'h0};
        endcase
    endfunction

    function automatic logic [55:0] seen_of(input logic [7:0] c, input scpd_pkg::scpd_fmt_type f,
        input logic [31:0] v, input logic [6:0] o, input logic [6:0] l);
        logic [31:0] vv;
        vv = (f == scpd_pkg::FMT_W7 || f == scpd_pkg::FMT_W32) ? v : 32'h0;
        return {c, f, vv, (f == scpd_pkg::FMT_READ) ? {o, l} : 14'h0};
    endfunction

    function automatic logic [6:0] crc2(input logic [15:0] m);
        logic [6:0] c;
        c = 7'h00;
        for (int i = 0; i < 16; i++) begin
            c = (c >> 1) ^ ((c[0] ^ m[i]) ? 7'h48 : 7'h00);
        end
        return c;
    endfunction

    task automatic check(input logic [55:0] seen, input logic [55:0] want);
        comparisons++;
        if (seen !== want) begin
            err_total++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic send(input logic [7:0] c, input logic [31:0] v, input logic a, input logic [6:0] n,
        input logic hit);
        int k;
        logic [55:0] e;
        k = 0;
        e = exp_of(c, v);
        // A new read restarts the reply count, so the previous reply must be out first
        if (c[6:4] == 3'h2) begin
            while (rsp_q.size() != 0 && k < 3000) begin
                @(negedge clk);
                k++;
            end
            if (k >= 3000) begin
                check(56'h1, 56'h0);
                report_and_stop();
            end
            k = 0;
        end
        if (hit) begin
            ev_q.push_back(e);
            for (int i = 0; c[6:4] == 3'h2 && i < e[6:0]; i++) begin
                rsp_q.push_back(({1'b0, v[6:0]} + 8'(i)) ^ 8'hC3);
            end
        end
        @(posedge clk);
        req_valid <= 1'b1;
        req_cmd <= c;
        req_value <= v;
        req_addr <= a;
        req_node <= n;
        do begin
            @(negedge clk);
            k++;
        end while (!req_ready && k < 100);
        if (k >= 100) begin
            check(56'h1, 56'h0);
            report_and_stop();
        end
        @(posedge clk);
        req_valid <= 1'b0;
    endtask

    task automatic drain(input string name);
        int k;
        k = 0;
        while ((ev_q.size() != 0 || rsp_q.size() != 0 || hbusy !== 1'b0 || tx_busy !== 1'b0) && k < 3000) begin
            @(negedge clk);
            k++;
        end
        repeat (6) @(negedge clk);
        check(56'(ev_q.size() + rsp_q.size()), 56'h0);
        if (k >= 3000) begin
            check(56'h1, 56'h0);
            report_and_stop();
        end
        $display("test %s done", name);
    endtask

    task automatic cfg(input logic nw, input logic [6:0] nd, input logic cw, input logic cd);
        @(posedge clk);
        node_wr <= nw;
        node_din <= nd;
        crc_wr <= cw;
        crc_din <= cd;
        @(posedge clk);
        node_wr <= 1'b0;
        crc_wr <= 1'b0;
    endtask

    task automatic raw(input logic [7:0] b);
        @(posedge clk);
        lnk2.cmd_valid <= 1'b1;
        lnk2.cmd_byte <= b;
    endtask

    task automatic raw_end();
        @(posedge clk);
        lnk2.cmd_valid <= 1'b0;
        lnk2.cmd_byte <= ~lnk2.cmd_byte;
    endtask

    always @(posedge clk) begin
        hrsp_ready <= 1'($random(seed));
        if (!src_valid || src_ready) begin
            src_valid <= 1'($random(seed));
        end
        if (exec_valid === 1'b1) begin
            check(seen_of(exec_cmd, exec_fmt, exec_value, exec_offset, exec_len), ev_q.pop_front());
        end
        if (ev2 === 1'b1) begin
            check(seen_of(ec2, ef2, evl2, eo2, el2), ev_q.pop_front());
        end
        if (crc_error === 1'b1 || ce2 === 1'b1) begin
            check(56'hE, ev_q.pop_front());
        end
        if (hrsp_valid === 1'b1 && hrsp_ready) begin
            check({48'h0, hrsp_data}, {48'h0, rsp_q.pop_front()});
        end
    end

    initial begin
        lnk2.cmd_valid = 1'b0;
        lnk2.cmd_byte = 8'h00;
        lnk2.rsp_ready = 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check({49'h0, node_num}, 56'h0E);
        check({55'h0, crc_en}, 56'h0);
        send(8'h94, 32'h3, 1'b0, 7'h00, 1'b1);
        send(8'hC0, 32'd1234567890, 1'b0, 7'h00, 1'b1);
        send(8'hA1, 32'h0005, 1'b0, 7'h00, 1'b1);
        send(8'hA2, 32'h1003, 1'b0, 7'h00, 1'b1);
        for (int i = 0; i < 24; i++) begin
            send({1'b1, 3'(i), 1'b0, 3'($random(seed))}, $random(seed), 1'b0, 7'h00, 1'b1);
        end
        drain("formats");
        send(8'h94, 32'h5, 1'b1, 7'h0E, 1'b1);
        send(8'hC1, $random(seed), 1'b1, 7'h05, 1'b0);
        cfg(1'b1, 7'h21, 1'b0, 1'b0);
        @(negedge clk);
        check({49'h0, node_num}, 56'h21);
        send(8'hA3, 32'h0420, 1'b1, 7'h21, 1'b1);
        send(8'h92, 32'h7, 1'b1, 7'h0E, 1'b0);
        drain("addressed");
        ev_q.push_back(exp_of(8'h91, 32'h6));
        raw(8'h05);
        raw(8'h94);
        raw(8'h91);
        raw(8'h06);
        raw_end();
        drain("restart");
        cfg(1'b0, 7'h00, 1'b1, 1'b1);
        hcrc <= 1'b1;
        @(negedge clk);
        check({55'h0, crc_en}, 56'h1);
        send(8'hD5, $random(seed), 1'b0, 7'h00, 1'b1);
        send(8'hA4, 32'h0F10, 1'b1, 7'h21, 1'b1);
        // Both devices share one note queue, so the host packets must finish first
        drain("checksum host");
        ev_q.push_back(exp_of(8'h94, 32'h5));
        raw(8'h94);
        raw(8'h05);
        raw({1'b0, crc2(16'h0594)});
        ev_q.push_back(56'hE);
        raw(8'h94);
        raw(8'h05);
        raw({1'b0, crc2(16'h0594) ^ 7'h01});
        raw_end();
        drain("checksum");
        report_and_stop();
    end
endmodule
`default_nettype wire
